// *** core/mdma_core.sv ***
// Multichannel DMA engine: 6 channels or 12 split halves, own buses.
// Assumes memory answers reads one cycle after the request and may
// stall writes with wrReady; the core's conflicting request is cpuReq.
//
// Notes on behaviour
// RQ1: Engine runs beside the core on its own read and write buses.
// RQ2: Six channels, or twelve streams when split mode is selected.
// RQ3: Any source to any destination address; port FIFOs are addresses.
// RQ4: A task starts on a core interrupt or an external interrupt line.
// RQ5: Task completion may raise an interrupt pulse to the core.
// RQ6: Per-channel link pointer; autoinit fetches next task from memory.
// RQ7: Split mode gives each channel an input half and an output half; both halves here are full source-to-destination slots.
// RQ8: Conflicts resolved: core wins, engine wins, or core then engine.
// RQ9: One word move with address and count update per cycle.
// RQ10: Port FIFOs are serviced as ordinary memory locations.
// RQ11: Task ends at zero count, raises done, autoinits if enabled.
`timescale 1ns/1ps
`include "mdma_defs.svh"

module mdma_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic splitMode,
    input wire mdma_pkg::mdma_pri_type priMode,
    input wire logic cfgWr,
    input wire logic [`MDMA_SLOT_W-1:0] cfgSlot,
    input wire logic [`MDMA_WORD_W-1:0] cfgSrc,
    input wire logic [`MDMA_WORD_W-1:0] cfgDst,
    input wire logic [`MDMA_WORD_W-1:0] cfgCount,
    input wire logic [`MDMA_WORD_W-1:0] cfgLink,
    input wire logic cfgAutoInit,
    input wire logic cfgIrqEn,
    input wire logic cfgTrigExt,
    input wire logic [1:0] cfgExtSel,
    input wire logic cfgStartNow,
    input wire logic [`MDMA_SLOTS-1:0] cpuTrig,
    input wire logic [`MDMA_EXT_LINES-1:0] extIntPin,
    input wire logic cpuReq,
    output logic cpuGnt,
    output logic rdReq,
    output logic [`MDMA_WORD_W-1:0] rdAddr,
    input wire logic [`MDMA_WORD_W-1:0] rdData,
    output logic wrReq,
    input wire logic wrReady,
    output logic [`MDMA_WORD_W-1:0] wrAddr,
    output logic [`MDMA_WORD_W-1:0] wrData,
    output logic [`MDMA_SLOTS-1:0] busy,
    output logic [`MDMA_SLOTS-1:0] doneEvt,
    output logic [`MDMA_SLOTS-1:0] cpuIrq
);
    import mdma_pkg::*;

    localparam int N = `MDMA_SLOTS;
    localparam int SW = `MDMA_SLOT_W;
    localparam int WW = `MDMA_WORD_W;
    localparam int LW = `MDMA_LEVEL_W;

    // ****************************************
    // External interrupt synchronisers
    // ****************************************
    logic [`MDMA_EXT_LINES-1:0] ext1_q, ext2_q, ext3_q, extLvl_q, extLvl_d;
    logic [`MDMA_EXT_LINES-1:0] extRise;

    always_comb begin
        extLvl_d = extLvl_q;
        extRise = '0;
        for (int k = 0; k < `MDMA_EXT_LINES; k++) begin
            if (ext2_q[k] == ext3_q[k]) begin
                extLvl_d[k] = ext3_q[k];
                extRise[k] = ext3_q[k] && !extLvl_q[k]; // RQ4
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ext1_q <= '0;
            ext2_q <= '0;
            ext3_q <= '0;
            extLvl_q <= '0;
        end else begin
            ext1_q <= extIntPin;
            ext2_q <= ext1_q;
            ext3_q <= ext2_q;
            extLvl_q <= extLvl_d;
        end
    end

    // ****************************************
    // Slot state
    // ****************************************
    logic [WW-1:0] src_q [N];
    logic [WW-1:0] dst_q [N];
    logic [WW-1:0] cnt_q [N];
    logic [WW-1:0] link_q [N];
    logic [N-1:0] run_q, armed_q, fetch_q, autoI_q, irqEn_q, trigExt_q;
    logic [1:0] extSel_q [N];
    mdma_fidx_type fIdx_q [N];
    logic [N-1:0] want;
    logic [LW-1:0] level;
    logic room;

    // Tag: fetch, slot, index, last, irq, destination
    logic v1_q, v2_q;
    logic [`MDMA_TAG_W-1:0] t1_q, t2_q, tIss;
    logic [WW-1:0] rdAddr_q, issAddr;
    logic t2Fetch;
    logic [SW-1:0] t2Slot;
    mdma_fidx_type t2Idx;

    assign t2Fetch = t2_q[40];
    assign t2Slot = t2_q[39:36];
    assign t2Idx = t2_q[35:34];

    // Two reads may be in flight, so keep room for them
    assign room = ({1'b0, level} + {5'h0, v1_q} + {5'h0, v2_q})
        < 6'(`MDMA_FIFO_DEPTH); // RQ9

    // ****************************************
    // Arbitration and slot selection
    // ****************************************
    logic anyWant, dmaGo, cpuLast_q, cpuLast_d;
    logic [SW-1:0] ptr_q, ptr_d, sel;

    assign anyWant = |want;

    always_comb begin
        dmaGo = 1'b0;
        cpuGnt = 1'b0;
        cpuLast_d = cpuLast_q;
        unique case (priMode)
            MDMA_PRI_CPU: begin
                cpuGnt = cpuReq;
                dmaGo = !cpuReq; // RQ8
            end
            MDMA_PRI_DMA: begin
                dmaGo = 1'b1;
                cpuGnt = cpuReq && !anyWant; // RQ8
            end
            MDMA_PRI_MIXED: begin
                // Core goes first, engine takes the next turn
                cpuGnt = cpuReq && (!anyWant || !cpuLast_q); // RQ8
                dmaGo = !cpuGnt;
                if (cpuReq && anyWant) begin
                    cpuLast_d = cpuGnt;
                end
            end
            default: begin
                cpuGnt = cpuReq;
                dmaGo = !cpuReq;
            end
        endcase
    end

    always_comb begin
        logic [SW-1:0] idx;
        logic found;
        idx = '0;
        found = 1'b0;
        sel = '0;
        for (int k = 0; k < N; k++) begin
            idx = SW'((32'(ptr_q) + k) % N);
            if (!found && want[idx]) begin
                found = 1'b1;
                sel = idx;
            end
        end
        ptr_d = ptr_q;
        if (found && dmaGo) begin
            ptr_d = (sel == SW'(N - 1)) ? '0 : sel + 1'b1;
        end
    end

    logic issue;
    assign issue = anyWant && dmaGo;

    always_comb begin
        issAddr = fetch_q[sel] ? link_q[sel] + WW'(fIdx_q[sel])
            : src_q[sel]; // RQ3 RQ6
        tIss = {fetch_q[sel], sel, fIdx_q[sel], cnt_q[sel] == 32'h1,
            irqEn_q[sel], dst_q[sel]};
    end

    // ****************************************
    // Per-slot task registers
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gSlot
            logic [WW-1:0] srcD, dstD, cntD, linkD;
            logic runD, armedD, fetchD, autoD, irqD, trigD, hit, arrive;
            logic [1:0] extD;
            mdma_fidx_type fIdxD;
            logic slotOn;

            // Odd halves exist only in split mode; their writes are dropped
            assign slotOn = (g % 2 == 0) || splitMode; // RQ2 RQ7
            assign want[g] = slotOn &&
                ((run_q[g] && cnt_q[g] != '0 && room) || fetch_q[g]);
            assign hit = issue && sel == SW'(g);
            assign arrive = v2_q && t2Fetch && t2Slot == SW'(g);
            assign busy[g] = run_q[g] || fetch_q[g];

            always_comb begin
                srcD = src_q[g];
                dstD = dst_q[g];
                cntD = cnt_q[g];
                linkD = link_q[g];
                runD = run_q[g];
                armedD = armed_q[g];
                fetchD = fetch_q[g];
                autoD = autoI_q[g];
                irqD = irqEn_q[g];
                trigD = trigExt_q[g];
                extD = extSel_q[g];
                fIdxD = fIdx_q[g];
                if (cfgWr && cfgSlot == SW'(g) && slotOn) begin // RQ7
                    srcD = cfgSrc;
                    dstD = cfgDst;
                    cntD = cfgCount;
                    linkD = cfgLink;
                    autoD = cfgAutoInit;
                    irqD = cfgIrqEn;
                    trigD = cfgTrigExt;
                    extD = cfgExtSel;
                    runD = cfgStartNow;
                    armedD = !cfgStartNow;
                    fetchD = 1'b0;
                end else begin
                    if (armed_q[g] && (trigExt_q[g] ?
                        extRise[extSel_q[g]] : cpuTrig[g])) begin
                        runD = 1'b1; // RQ4
                        armedD = 1'b0;
                    end
                    if (hit && fetch_q[g]) begin
                        fIdxD = fIdx_q[g] + 1'b1;
                        fetchD = fIdx_q[g] != `MDMA_FETCH_LAST;
                    end else if (hit) begin
                        srcD = src_q[g] + 1'b1; // RQ9
                        dstD = dst_q[g] + 1'b1;
                        cntD = cnt_q[g] - 1'b1;
                        if (cnt_q[g] == 32'h1) begin
                            runD = 1'b0; // RQ11
                            fetchD = autoI_q[g];
                            fIdxD = '0;
                        end
                    end
                    if (arrive) begin
                        unique case (t2Idx)
                            2'h0: srcD = rdData;
                            2'h1: dstD = rdData;
                            2'h2: cntD = rdData;
                            2'h3: begin
                                linkD = rdData; // RQ6
                                runD = 1'b1;
                            end
                        endcase
                    end
                end
            end

            always_ff @(posedge clk) begin
                if (rst) begin
                    src_q[g] <= '0;
                    dst_q[g] <= '0;
                    cnt_q[g] <= '0;
                    link_q[g] <= '0;
                    run_q[g] <= 1'b0;
                    armed_q[g] <= 1'b0;
                    fetch_q[g] <= 1'b0;
                    autoI_q[g] <= 1'b0;
                    irqEn_q[g] <= 1'b0;
                    trigExt_q[g] <= 1'b0;
                    extSel_q[g] <= 2'h0;
                    fIdx_q[g] <= 2'h0;
                end else begin
                    src_q[g] <= srcD;
                    dst_q[g] <= dstD;
                    cnt_q[g] <= cntD;
                    link_q[g] <= linkD;
                    run_q[g] <= runD;
                    armed_q[g] <= armedD;
                    fetch_q[g] <= fetchD;
                    autoI_q[g] <= autoD;
                    irqEn_q[g] <= irqD;
                    trigExt_q[g] <= trigD;
                    extSel_q[g] <= extD;
                    fIdx_q[g] <= fIdxD;
                end
            end
        end
    endgenerate

    // ****************************************
    // Read pipeline, data FIFO and write side
    // ****************************************
    logic fOutValid, wrFire;
    logic [`MDMA_FIFO_W-1:0] fOut;
    logic [N-1:0] doneEvt_q, doneEvt_d, cpuIrq_q, cpuIrq_d;

    always_ff @(posedge clk) begin
        if (rst) begin
            v1_q <= 1'b0;
            v2_q <= 1'b0;
            t1_q <= '0;
            t2_q <= '0;
            rdAddr_q <= '0;
            ptr_q <= '0;
            cpuLast_q <= 1'b0;
            doneEvt_q <= '0;
            cpuIrq_q <= '0;
        end else begin
            v1_q <= issue; // RQ1
            v2_q <= v1_q;
            t1_q <= tIss;
            t2_q <= t1_q;
            rdAddr_q <= issue ? issAddr : rdAddr_q;
            ptr_q <= ptr_d;
            cpuLast_q <= cpuLast_d;
            doneEvt_q <= doneEvt_d;
            cpuIrq_q <= cpuIrq_d;
        end
    end

    assign rdReq = v1_q;
    assign rdAddr = rdAddr_q;

    // Room check keeps inReady high whenever a data word lands
    mdma_fifo #(
        .WIDTH(`MDMA_FIFO_W),
        .DEPTH(`MDMA_FIFO_DEPTH),
        .AW(4)
    ) uFifo (
        .clk(clk),
        .rst(rst),
        .inValid(v2_q && !t2Fetch),
        .inReady(),
        // Read word stands on the bus only in the cycle after rdReq
        .inData({t2_q[39:36], t2_q[33:32], t2_q[31:0], rdData}),
        .outValid(fOutValid),
        .outReady(wrReady),
        .outData(fOut),
        .level(level)
    ); // RQ10

    assign wrReq = fOutValid;
    assign wrAddr = fOut[63:32];
    assign wrData = fOut[31:0];
    assign wrFire = fOutValid && wrReady;

    always_comb begin
        doneEvt_d = '0;
        cpuIrq_d = '0;
        if (wrFire && fOut[65]) begin
            doneEvt_d[fOut[69:66]] = 1'b1; // RQ11
            cpuIrq_d[fOut[69:66]] = fOut[64]; // RQ5
        end
    end

    assign doneEvt = doneEvt_q;
    assign cpuIrq = cpuIrq_q;

endmodule // mdma_core

// *** core/mdma_defs.svh ***
// Constants of the multichannel DMA engine: sizes, counts, tag width.
// Assumes inclusion by the package and the design modules only.
`ifndef MDMA_DEFS_SVH
`define MDMA_DEFS_SVH

`define MDMA_WORD_W 32
`define MDMA_CHANS 6
`define MDMA_SLOTS 12
`define MDMA_SLOT_W 4
`define MDMA_EXT_LINES 4
`define MDMA_FIFO_DEPTH 16
`define MDMA_LEVEL_W 5
`define MDMA_FETCH_LAST 2'h3
`define MDMA_FIFO_W 70
`define MDMA_TAG_W 41

`endif

// *** core/mdma_pkg.sv ***
// Types shared by the multichannel DMA engine and its users.
// Assumes mdma_defs.svh sits in the include path.
`include "mdma_defs.svh"

package mdma_pkg;

    // Arbitration policy against the processor core
    typedef enum logic [1:0] {
        MDMA_PRI_CPU = 2'b00,
        MDMA_PRI_DMA = 2'b01,
        MDMA_PRI_MIXED = 2'b10
    } mdma_pri_type;

    // Autoinit fetch word index
    typedef logic [1:0] mdma_fidx_type;

endpackage

// *** core/mdma_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
`include "mdma_defs.svh"

module mdma_fifo #(
    parameter int WIDTH = `MDMA_FIFO_W,
    parameter int DEPTH = `MDMA_FIFO_DEPTH,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [AW:0] level
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign inReady = (cnt_q != DEPTH[AW:0]);
    assign outValid = (cnt_q != '0);
    assign outData = mem_q[rdPtr_q];
    assign level = cnt_q;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            cnt_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage needs no reset; empty flag guards stale words
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

endmodule // mdma_fifo

// *** bench/mdma_mem_model.sv ***
// Memory model for the DMA engine's own read and write buses.
// Assumes reads answer one cycle after rdReq; stall holds off writes.
`timescale 1ns/1ps
// ****
// Memory
// ****
module mdma_mem_model (
    input wire logic clk,
    input wire logic rdReq,
    input wire logic [31:0] rdAddr,
    output logic [31:0] rdData,
    input wire logic wrReq,
    output logic wrReady,
    input wire logic [31:0] wrAddr,
    input wire logic [31:0] wrData,
    input wire logic stall
);
    logic [31:0] mem [logic [31:0]];
    // Unwritten words read back as a mix of their address
    function automatic logic [31:0] peek(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : a ^ 32'h5A5A_0000;
    endfunction
    initial rdData = 32'h0000_0000;
    initial wrReady = 1'b0;
    always @(posedge clk) begin
        // Data lines change every idle cycle, never hold a stale word
        rdData <= #1 rdReq ? peek(rdAddr) : ~rdData;
        if (wrReq && wrReady) begin
            mem[wrAddr] = wrData;
        end
        wrReady <= #1 !stall && ($urandom_range(3) != 0);
    end
endmodule // mdma_mem_model

// *** bench/mdma_core_assertions.sv ***
// Port checker for mdma_core.
// Assumes it is bound into every mdma_core instance.
`timescale 1ns/1ps
// ****
// Checker
// ****
module mdma_core_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic splitMode,
    input wire mdma_pkg::mdma_pri_type priMode,
    input wire logic cpuReq,
    input wire logic cpuGnt,
    input wire logic rdReq,
    input wire logic wrReq,
    input wire logic wrReady,
    input wire logic [31:0] wrAddr,
    input wire logic [31:0] wrData,
    input wire logic [11:0] busy,
    input wire logic [11:0] doneEvt,
    input wire logic [11:0] cpuIrq
);
    import mdma_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence core_lost_s;
        priMode == MDMA_PRI_MIXED && cpuReq && !cpuGnt;
    endsequence
    sequence core_again_s;
        cpuReq && priMode == MDMA_PRI_MIXED;
    endsequence
    quiet_reset_a: assert property ($fell(rst) |-> busy == 0
        && doneEvt == 0 && !rdReq && !wrReq) else $error("not idle");
    core_wins_a: assert property (priMode == MDMA_PRI_CPU
        && cpuReq |-> cpuGnt) else $error("core not granted");
    grant_req_a: assert property (cpuGnt |-> cpuReq)
        else $error("grant without request");
    mixed_turn_a: assert property (core_lost_s ##1 core_again_s
        |-> cpuGnt) else $error("core lost twice");
    write_hold_a: assert property (wrReq && !wrReady |=> wrReq
        && $stable(wrAddr) && $stable(wrData)) else $error("write moved");
    done_pulse_a: assert property (doneEvt != 0
        |=> (doneEvt & $past(doneEvt)) == 0) else $error("long done");
    done_write_a: assert property (doneEvt != 0
        |-> $past(wrReq && wrReady)) else $error("done without write");
    irq_gated_a: assert property ((cpuIrq & ~doneEvt) == 0)
        else $error("irq without done");
    read_busy_a: assert property (rdReq |-> $past(busy) != 0)
        else $error("read while idle");
    split_off_a: assert property (!splitMode
        |-> (busy & 12'hAAA) == 0) else $error("odd slot ran");
endmodule // mdma_core_assertions
bind mdma_core mdma_core_assertions chk (.clk, .rst, .splitMode,
    .priMode, .cpuReq, .cpuGnt, .rdReq, .wrReq, .wrReady, .wrAddr,
    .wrData, .busy, .doneEvt, .cpuIrq);

// *** bench/mdma_core_bench.sv ***
// Self-checking bench for mdma_core with random tasks.
// Assumes the memory model and the bound checker are compiled.
`timescale 1ns/1ps
// ****
// Bench
// ****
module mdma_core_bench;
    import mdma_pkg::*;
    logic clk, rst, splitMode, cfgWr, cfgAutoInit, cfgIrqEn, cfgTrigExt;
    logic cfgStartNow, cpuReq, cpuGnt, rdReq, wrReq, wrReady, stall;
    mdma_pri_type priMode;
    logic [3:0] cfgSlot, extIntPin;
    logic [1:0] cfgExtSel;
    logic [31:0] cfgSrc, cfgDst, cfgCount, cfgLink, rdAddr, rdData;
    logic [31:0] wrAddr, wrData;
    logic [11:0] cpuTrig, busy, doneEvt, cpuIrq;
    logic [31:0] gotA [$];
    logic [31:0] gotD [$];
    int failures, compares, rdCount;
    mdma_core dut (.clk, .rst, .splitMode, .priMode, .cfgWr, .cfgSlot,
        .cfgSrc, .cfgDst, .cfgCount, .cfgLink, .cfgAutoInit, .cfgIrqEn,
        .cfgTrigExt, .cfgExtSel, .cfgStartNow, .cpuTrig, .extIntPin,
        .cpuReq, .cpuGnt, .rdReq, .rdAddr, .rdData, .wrReq, .wrReady,
        .wrAddr, .wrData, .busy, .doneEvt, .cpuIrq);
    mdma_mem_model model (.clk, .rdReq, .rdAddr, .rdData, .wrReq,
        .wrReady, .wrAddr, .wrData, .stall);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Random core traffic keeps arbitration busy in every mode
    always @(posedge clk) begin
        cpuReq <= #1 ($urandom_range(3) == 0);
        if (rdReq === 1'b1) rdCount++;
        if (wrReq === 1'b1 && wrReady === 1'b1) begin
            gotA.push_back(wrAddr);
            gotD.push_back(wrData);
        end
    end
    function automatic logic [31:0] word_at(input logic [31:0] a);
        return a ^ 32'h5A5A_0000;
    endfunction
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic final_report;
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cfg(input logic [3:0] s, input logic [31:0] sr, ds,
        n, ln, input logic au, ie, te, input logic [1:0] es,
        input logic now, sp);
        @(posedge clk);
        #1;
        {cfgWr, cfgSlot, cfgSrc, cfgDst, cfgCount, cfgLink} =
            {1'b1, s, sr, ds, n, ln};
        {cfgAutoInit, cfgIrqEn, cfgTrigExt, cfgExtSel} = {au, ie, te, es};
        {cfgStartNow, splitMode} = {now, sp};
        @(posedge clk);
        #1 cfgWr = 1'b0;
    endtask
    task automatic wait_done(input int s, output logic irq);
        for (int k = 0; k < 3000; k++) begin
            @(posedge clk);
            #1;
            if (doneEvt[s] === 1'b1) break;
        end
        chk(doneEvt[s] === 1'b1, "no done pulse");
        irq = cpuIrq[s];
    endtask
    task automatic writes(input logic [31:0] sr, ds, input int n);
        chk(gotA.size() == n, "write count");
        for (int i = 0; i < n && i < gotA.size(); i++) begin
            chk(gotA[i] === ds + i, "write address");
            chk(gotD[i] === word_at(sr + i), "write data");
        end
        gotA.delete();
        gotD.delete();
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report();
    end
    initial begin
        logic [31:0] src, dst;
        logic irq;
        int n, s, ln, rd0;
        {splitMode, cfgWr, cfgSlot, cfgSrc, cfgDst, cfgCount} = '0;
        {cfgLink, cfgAutoInit, cfgIrqEn, cfgTrigExt, cfgExtSel} = '0;
        {cfgStartNow, cpuTrig, extIntPin, stall} = '0;
        {failures, compares} = '0;
        priMode = MDMA_PRI_CPU;
        rst = 1'b1;
        void'($urandom(57946));
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        // Odd slot without split mode, trigger on an unarmed slot
        cfg(1, 32'h10, 32'h8000_0000, 2, 0, 0, 0, 0, 0, 1, 0);
        cpuTrig[3] = 1'b1;
        @(posedge clk);
        #1 cpuTrig = '0;
        repeat (6) @(posedge clk);
        #1;
        chk(busy === 12'h000 && gotA.size() == 0, "idle slot ran");
        for (int i = 0; i < 4; i++) begin
            s = (i == 3) ? 1 : 2 * i;
            priMode = mdma_pri_type'(i);
            src = $urandom_range(16'hFFF0);
            dst = 32'h8000_0000 | $urandom_range(16'hFFFF);
            n = $urandom_range(6, 1);
            ln = $urandom_range(3);
            cfg(s, src, dst, n, 0, 0, !i[0], i == 2, ln, i != 1 && i != 2,
                i == 3);
            if (i == 1 || i == 2) begin
                repeat (5) @(posedge clk);
                #1;
                chk(busy[s] === 1'b0, "armed slot ran");
                cpuTrig[s] = (i == 1);
                extIntPin[ln] = (i == 2);
                repeat (4) @(posedge clk);
                #1 {cpuTrig, extIntPin} = '0;
            end
            wait_done(s, irq);
            chk(irq === !i[0], "irq select");
            writes(src, dst, n);
        end
        // Writes stalled: sixteen words fill the buffer, then reads stop
        stall = 1'b1;
        rd0 = rdCount;
        cfg(8, 32'h0100, 32'h9000_0000, 20, 0, 0, 0, 0, 0, 1, 1);
        repeat (40) @(posedge clk);
        #1;
        chk(rdCount - rd0 == 16 && wrReq === 1'b1, "buffer room");
        stall = 1'b0;
        wait_done(8, irq);
        writes(32'h0100, 32'h9000_0000, 20);
        // Chain of tasks; second descriptor has count 0 and parks
        model.mem[32'h4000_0000] = 32'h0200;
        model.mem[32'h4000_0001] = 32'hA000_0000;
        model.mem[32'h4000_0002] = 32'h0000_0003;
        model.mem[32'h4000_0003] = 32'h4000_0010;
        model.mem[32'h4000_0012] = 32'h0000_0000;
        cfg(10, 32'h0300, 32'hB000_0000, 2, 32'h4000_0000, 1, 1, 0, 0, 1,
            1);
        wait_done(10, irq);
        writes(32'h0300, 32'hB000_0000, 2);
        wait_done(10, irq);
        chk(irq === 1'b1, "chained irq");
        writes(32'h0200, 32'hA000_0000, 3);
        repeat (20) @(posedge clk);
        #1;
        chk(busy[10] === 1'b1 && gotA.size() == 0, "parked slot");
        rst = 1'b1;
        @(posedge clk);
        #1 rst = 1'b0;
        chk(busy === 12'h000 && wrReq === 1'b0, "second reset");
        final_report();
    end
endmodule // mdma_core_bench
